// File: rtl/ascd_top.sv
// Sample clock divider with duty cycle stabilizer and external sync.
//
// Function
// [RL1] Divide the input sample clock by an integer from 1 to 8.
// [RL2] Software should enable the stabilizer for ratios other than 1, 2, 4.
// [RL3] Sync control bits 1 and 2 pick resync on every or first sync.
// [RL4] A valid sync returns the divider counter to its initial state.
// [RL5] The sync input passes a clocked synchronizer before acting.
// [RL6] The board should align sync to the input clock for all devices.
// [RL7] Stabilizer on: internal clock high about half of each divided period.
// [RL8] Stabilizer does not run or lock below 20 MHz divided rate.
// [RL9] After a rate change software waits 1.5 to 5 us for relock.
// [RL10] Each sample is taken on the rising edge of the conversion clock.
// [RL11] First-sync mode ignores later syncs until the register is rewritten.
// [RL12] A new ratio takes effect only at terminal count, with no runt pulse; the code also loads it on a valid sync.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "ascd_params.svh"

module ascd_top #(
   parameter int REF_MHZ = `ASCD_REF_MHZ,
   parameter int REF_PERIOD_PS = `ASCD_REF_PERIOD_PS,
   parameter int SYNC_STAGES = `ASCD_SYNC_STAGES
) (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire ascd_pkg::ascd_bus_req_s bus_req_in,
   output logic [`ASCD_DATA_W-1:0] rd_data_out,
   input wire logic sync_in,
   output logic conv_clk_out,
   output logic sample_strobe_out,
   output logic dcs_active_out,
   output logic dcs_locked_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Constants and helper functions.

   localparam int DIV_W = `ASCD_DIV_W;
   localparam int DATA_W = `ASCD_DATA_W;
   localparam int ADDR_W = `ASCD_ADDR_W;
   localparam int RELOCK_RAW =
      (`ASCD_DCS_RELOCK_NS * `ASCD_PS_PER_NS + REF_PERIOD_PS - 1)
      / REF_PERIOD_PS;
   localparam int RELOCK_INT = (RELOCK_RAW < 1) ? 1 : RELOCK_RAW;
   localparam int LOCK_W = $clog2(RELOCK_INT + 1);
   localparam logic [LOCK_W-1:0] RELOCK_CYC = LOCK_W'(RELOCK_INT);

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction

   // The stabilizer loop cannot follow a divided rate under its floor.
   function automatic logic rate_ok(input logic [DIV_W-1:0] code);
      int ratio;
      ratio = int'(code) + 1;
      return REF_MHZ >= `ASCD_DCS_MIN_MHZ * ratio; // RL8
   endfunction

   // High time in input cycles for one divided period.
   function automatic logic [DIV_W:0] high_len(input logic [DIV_W-1:0] code,
                                               input logic duty_cycle_stabilizer);
      logic [DIV_W:0] ratio;
      ratio = {1'b0, code} + (DIV_W+1)'(1);
      if (duty_cycle_stabilizer) begin
         return (ratio + (DIV_W+1)'(1)) >> 1; // RL7
      end
      return (DIV_W+1)'(1);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register bus decode.

   wire wr_dcs = bus_req_in.wr && addr_hit(bus_req_in.addr,
                                           `ASCD_OFS_DCS_CTRL);
   wire wr_div = bus_req_in.wr && addr_hit(bus_req_in.addr,
                                           `ASCD_OFS_CLK_DIV);
   wire wr_sync = bus_req_in.wr && addr_hit(bus_req_in.addr,
                                            `ASCD_OFS_SYNC_CTRL);
   wire rd_dcs = addr_hit(bus_req_in.addr, `ASCD_OFS_DCS_CTRL);
   wire rd_div = addr_hit(bus_req_in.addr, `ASCD_OFS_CLK_DIV);
   wire rd_sync = addr_hit(bus_req_in.addr, `ASCD_OFS_SYNC_CTRL);
   wire rd_stat = addr_hit(bus_req_in.addr, `ASCD_OFS_STATUS);

   logic dcs_en_reg;
   logic [DIV_W-1:0] div_code_reg;
   logic [DATA_W-1:0] sync_ctrl_reg;
   logic armed_reg;
   logic seen_reg;
   logic [DATA_W-1:0] rd_data_reg;

   wire dcs_en_next = wr_dcs ? bus_req_in.wdata[`ASCD_DCS_EN_BIT]
                             : dcs_en_reg;
   wire [DIV_W-1:0] div_code_next = wr_div ? bus_req_in.wdata[DIV_W-1:0]
                                           : div_code_reg;
   wire [DATA_W-1:0] sync_ctrl_next = wr_sync ? bus_req_in.wdata
                                              : sync_ctrl_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Sync input path.

   logic sync_q;
   logic sync_q_d_reg;

   ascd_sync #(
      .STAGES(SYNC_STAGES)
   ) u_sync (
      .clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .d_in(sync_in),
      .q_out(sync_q)
   ); // RL5

   wire sync_rise = sync_q && !sync_q_d_reg;
   wire sync_en = sync_ctrl_reg[`ASCD_SYNC_EN_BIT]; // RL3
   wire sync_first = sync_ctrl_reg[`ASCD_SYNC_FIRST_BIT]; // RL3
   // Later syncs are dropped in single-shot mode until re-armed.
   wire sync_valid = sync_rise && sync_en && (!sync_first || armed_reg); // RL11

   // A write re-arms and wins over a sync consumed in the same cycle.
   wire armed_next = wr_sync ? 1'b1
                   : ((sync_valid && sync_first) ? 1'b0 : armed_reg); // RL11
   wire seen_next = sync_valid ? 1'b1 : (wr_sync ? 1'b0 : seen_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Divider counter.

   logic [DIV_W-1:0] cnt_reg;
   logic [DIV_W-1:0] ratio_act_reg;
   logic conv_clk_reg;
   logic strobe_reg;
   logic dcs_hi_reg;

   wire terminal = cnt_reg == ratio_act_reg;
   // The ratio switches at a period boundary or on a valid sync, which also restarts the count.
   wire ratio_load = terminal || sync_valid; // RL12
   wire [DIV_W-1:0] ratio_next = ratio_load ? div_code_reg
                                            : ratio_act_reg; // RL12
   wire [DIV_W-1:0] cnt_next = (sync_valid || terminal) ? '0
                             : cnt_reg + DIV_W'(1); // RL1 RL4
   wire ratio_change = ratio_load && (ratio_next != ratio_act_reg);

   wire dcs_act_next = dcs_en_next && rate_ok(ratio_next); // RL8
   // The duty choice is held for a whole period, so a stabilizer toggle
   // in mid-period cannot add a rising edge that carries no strobe.
   wire dcs_hi_next = ratio_load ? dcs_act_next : dcs_hi_reg; // RL12
   wire [DIV_W:0] high_next = high_len(ratio_next, dcs_hi_next); // RL7
   // With ratio 1 the clock stays high and the strobe marks every edge.
   wire conv_clk_next = {1'b0, cnt_next} < high_next; // RL1
   wire strobe_next = cnt_next == '0; // RL10

   ////////////////////////////////////////////////////////////////////////////
   // Stabilizer lock tracking.

   ascd_pkg::ascd_dcs_state_e dcs_state_reg;
   ascd_pkg::ascd_dcs_state_e dcs_state_next;
   logic [LOCK_W-1:0] lock_cnt_reg;
   logic [LOCK_W-1:0] lock_cnt_next;

   // Any rate change drops lock, so software can see when to trust samples.
   always_comb begin
      dcs_state_next = dcs_state_reg;
      lock_cnt_next = lock_cnt_reg;
      case (dcs_state_reg)
         ascd_pkg::ASCD_DCS_OFF: begin
            if (dcs_act_next) begin
               dcs_state_next = ascd_pkg::ASCD_DCS_RELOCK;
               lock_cnt_next = RELOCK_CYC;
            end
         end
         ascd_pkg::ASCD_DCS_RELOCK: begin
            if (!dcs_act_next) begin
               dcs_state_next = ascd_pkg::ASCD_DCS_OFF;
            end else if (ratio_change) begin
               lock_cnt_next = RELOCK_CYC; // RL9
            end else if (lock_cnt_reg == '0) begin
               dcs_state_next = ascd_pkg::ASCD_DCS_LOCKED;
            end else begin
               lock_cnt_next = lock_cnt_reg - LOCK_W'(1);
            end
         end
         ascd_pkg::ASCD_DCS_LOCKED: begin
            if (!dcs_act_next) begin
               dcs_state_next = ascd_pkg::ASCD_DCS_OFF;
            end else if (ratio_change) begin
               dcs_state_next = ascd_pkg::ASCD_DCS_RELOCK; // RL9
               lock_cnt_next = RELOCK_CYC;
            end
         end
         default: begin
            dcs_state_next = ascd_pkg::ASCD_DCS_OFF;
            lock_cnt_next = '0;
         end
      endcase
   end

   wire locked_next = dcs_state_next == ascd_pkg::ASCD_DCS_LOCKED;

   ////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe and zero otherwise.

   logic dcs_active_reg;
   logic locked_reg;

   wire [DATA_W-1:0] stat_word =
      {1'b0, ratio_act_reg, seen_reg, dcs_active_reg, armed_reg, locked_reg};
   wire [DATA_W-1:0] rd_mux =
      rd_dcs ? {{(DATA_W-1){1'b0}}, dcs_en_reg}
      : rd_div ? {{(DATA_W-DIV_W){1'b0}}, div_code_reg}
      : rd_sync ? sync_ctrl_reg
      : rd_stat ? stat_word
      : '0;
   wire [DATA_W-1:0] rd_data_next = bus_req_in.rd ? rd_mux : '0;

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dcs_en_reg <= `ASCD_RST_DCS_EN;
         div_code_reg <= `ASCD_RST_DIV_CODE;
         sync_ctrl_reg <= `ASCD_RST_SYNC_CTRL;
         armed_reg <= 1'b0;
         seen_reg <= 1'b0;
         rd_data_reg <= '0;
      end else begin
         dcs_en_reg <= dcs_en_next;
         div_code_reg <= div_code_next;
         sync_ctrl_reg <= sync_ctrl_next;
         armed_reg <= armed_next;
         seen_reg <= seen_next;
         rd_data_reg <= rd_data_next;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sync_q_d_reg <= 1'b0;
         cnt_reg <= '0;
         ratio_act_reg <= `ASCD_RST_DIV_CODE;
         conv_clk_reg <= 1'b0;
         strobe_reg <= 1'b0;
         dcs_hi_reg <= 1'b0;
      end else begin
         sync_q_d_reg <= sync_q;
         cnt_reg <= cnt_next; // RL4
         ratio_act_reg <= ratio_next;
         conv_clk_reg <= conv_clk_next; // RL7
         strobe_reg <= strobe_next; // RL10
         dcs_hi_reg <= dcs_hi_next;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dcs_state_reg <= ascd_pkg::ASCD_DCS_OFF;
         lock_cnt_reg <= '0;
         dcs_active_reg <= 1'b0;
         locked_reg <= 1'b0;
      end else begin
         dcs_state_reg <= dcs_state_next;
         lock_cnt_reg <= lock_cnt_next;
         dcs_active_reg <= dcs_act_next; // RL8
         locked_reg <= locked_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign rd_data_out = rd_data_reg;
   assign conv_clk_out = conv_clk_reg;
   assign sample_strobe_out = strobe_reg;
   assign dcs_active_out = dcs_active_reg;
   assign dcs_locked_out = locked_reg;

endmodule

// File: shared/ascd_params.svh
// Offsets, field positions, reset values and timing figures of the divider.
`ifndef ASCD_PARAMS_SVH
`define ASCD_PARAMS_SVH

`define ASCD_ADDR_W 12
`define ASCD_DATA_W 8
`define ASCD_DIV_W 3

`define ASCD_OFS_DCS_CTRL 12'h009
`define ASCD_OFS_CLK_DIV 12'h00B
`define ASCD_OFS_SYNC_CTRL 12'h100
`define ASCD_OFS_STATUS 12'h102

`define ASCD_DCS_EN_BIT 0
`define ASCD_SYNC_EN_BIT 1
`define ASCD_SYNC_FIRST_BIT 2

`define ASCD_ST_LOCK_BIT 0
`define ASCD_ST_ARMED_BIT 1
`define ASCD_ST_DCS_BIT 2
`define ASCD_ST_SEEN_BIT 3
`define ASCD_ST_RATIO_LSB 4

`define ASCD_RST_SYNC_CTRL 8'h00
`define ASCD_RST_DCS_EN 1'b1
`define ASCD_RST_DIV_CODE 3'h0

`define ASCD_DCS_RELOCK_NS 1500
`define ASCD_DCS_MIN_MHZ 20
`define ASCD_REF_MHZ 100
`define ASCD_REF_PERIOD_PS 10000
`define ASCD_PS_PER_NS 1000
`define ASCD_SYNC_STAGES 2

`endif

// File: shared/ascd_pkg.sv
// Types shared by the sample clock divider files.
`include "ascd_params.svh"

package ascd_pkg;

   typedef struct packed {
      logic [`ASCD_ADDR_W-1:0] addr;
      logic [`ASCD_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } ascd_bus_req_s;

   typedef enum logic [1:0] {
      ASCD_DCS_OFF,
      ASCD_DCS_RELOCK,
      ASCD_DCS_LOCKED
   } ascd_dcs_state_e;

endpackage

// File: rtl/ascd_sync.sv
// Flip-flop chain that brings the external sync level into the clock domain.
`timescale 1ns/1ps

module ascd_sync #(
   parameter int STAGES = 2
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic d_in,
   output logic q_out
);

   logic stage_reg [STAGES];

   // Only the next stage reads each flop, so no logic sees a metastable level.
   genvar i;
   generate
      for (i = 0; i < STAGES; i++) begin : g_stage
         if (i == 0) begin : g_first
            always_ff @(posedge clk_in or negedge arst_n_in) begin
               if (!arst_n_in) begin
                  stage_reg[0] <= 1'b0;
               end else begin
                  stage_reg[0] <= d_in;
               end
            end
         end else begin : g_next
            always_ff @(posedge clk_in or negedge arst_n_in) begin
               if (!arst_n_in) begin
                  stage_reg[i] <= 1'b0;
               end else begin
                  stage_reg[i] <= stage_reg[i-1];
               end
            end
         end
      end
   endgenerate

   assign q_out = stage_reg[STAGES-1];

endmodule

// File: test/ascd_checker.sv
// Port-level assertions for the sample clock divider.
`timescale 1ns/1ps
`include "ascd_params.svh"

module ascd_checker (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire ascd_pkg::ascd_bus_req_s bus_req_in,
   input wire logic [`ASCD_DATA_W-1:0] rd_data_out,
   input wire logic sync_in,
   input wire logic conv_clk_out,
   input wire logic sample_strobe_out,
   input wire logic dcs_active_out,
   input wire logic dcs_locked_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);
   logic [7:0] ctrl_reg;
   logic [3:0] gap_reg;
   // Gap saturates so a stuck divider still trips the bound below.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctrl_reg <= 8'h00;
         gap_reg <= 4'h0;
      end else begin
         if (bus_req_in.wr && bus_req_in.addr == `ASCD_OFS_SYNC_CTRL)
            ctrl_reg <= bus_req_in.wdata;
         if (sample_strobe_out)
            gap_reg <= 4'h0;
         else if (gap_reg != 4'hF)
            gap_reg <= gap_reg + 4'h1;
      end
   end
   sequence s_sync_edge;
      $rose(sync_in) && ctrl_reg[`ASCD_SYNC_EN_BIT]
         && !ctrl_reg[`ASCD_SYNC_FIRST_BIT];
   endsequence
   sequence s_relock;
      ##140 !dcs_locked_out ##[1:20] (dcs_locked_out || !dcs_active_out);
   endsequence
   a_rd_idle_zero: assert property (
      !$past(bus_req_in.rd) |-> rd_data_out == 8'h00)
      else $error("read data outside its slot");
   a_strobe_conv_high: assert property (
      sample_strobe_out |-> conv_clk_out)
      else $error("strobe while conversion clock low");
   a_rise_gives_strobe: assert property (
      $rose(conv_clk_out) |-> sample_strobe_out)
      else $error("clock rose without strobe");
   a_sync_realign: assert property (
      s_sync_edge |-> ##3 sample_strobe_out)
      else $error("sync did not restart divider");
   a_lock_needs_active: assert property (
      !dcs_active_out |=> !dcs_locked_out)
      else $error("locked while stabilizer idle");
   a_relock_wait: assert property (
      $rose(dcs_active_out) |-> s_relock)
      else $error("relock time wrong");
   a_no_slow_dcs: assert property (
      gap_reg >= 4'h4 && !sample_strobe_out |-> !dcs_active_out)
      else $error("stabilizer active at slow rate");
   a_period_bound: assert property (
      gap_reg <= 4'h7)
      else $error("divided period above eight");
endmodule

////////////////////////////////////////
bind ascd_top ascd_checker u_chk (.ref_clk_in, .arst_n_in, .bus_req_in,
   .rd_data_out, .sync_in, .conv_clk_out, .sample_strobe_out,
   .dcs_active_out, .dcs_locked_out);

// File: test/ascd_sync_src.sv
// Board-side sync source: one short pulse per request.
`timescale 1ns/1ps

module ascd_sync_src (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic fire_in,
   input wire logic width_in,
   output logic sync_out
);
   logic left_reg;
   // Launched from the clock edge so every converter sees the same cycle.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         left_reg <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         left_reg <= fire_in & width_in;
         sync_out <= fire_in | left_reg;
      end
   end
endmodule

// File: test/testbench.sv
// Self-checking bench for the sample clock divider.
`timescale 1ns/1ps
`include "ascd_params.svh"

module testbench;
   logic ref_clk_in, arst_n_in, fire, width, d, act, ec, es;
   ascd_pkg::ascd_bus_req_s req;
   logic [`ASCD_DATA_W-1:0] rd_data_out;
   logic sync_in, conv_clk_out, sample_strobe_out;
   logic dcs_active_out, dcs_locked_out;
   int bad_count, samples_checked, cyc, i, k, r, h;

   ascd_top u_dut (.ref_clk_in, .arst_n_in, .bus_req_in(req),
      .rd_data_out, .sync_in, .conv_clk_out, .sample_strobe_out,
      .dcs_active_out, .dcs_locked_out);
   ascd_sync_src u_src (.clk_in(ref_clk_in), .arst_n_in, .fire_in(fire),
      .width_in(width), .sync_out(sync_in));

   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   ////////////////////////////////////////
   task tk;
      @(posedge ref_clk_in);
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
         bad_count++;
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] v);
      tk;
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      tk;
      req.wr <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
      tk;
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      tk;
      req.rd <= 1'b0;
      @(negedge ref_clk_in);
      chk(rd_data_out & m, e);
   endtask
   task do_sync(input logic e);
      tk;
      fire <= 1'b1;
      width <= 1'($urandom % 2);
      tk;
      fire <= 1'b0;
      repeat (3) tk;
      @(negedge ref_clk_in);
      chk({7'h00, sample_strobe_out}, {7'h00, e});
   endtask
   task tally_and_finish;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      cyc = 0;
      forever begin
         tk;
         cyc++;
         if (cyc == 20000) begin
            bad_count++;
            tally_and_finish;
         end
      end
   end

   initial begin
      arst_n_in = 1'b0;
      req = '0;
      fire = 1'b0;
      width = 1'b0;
      void'($urandom(32'he618));
      repeat (8) tk;
      arst_n_in <= 1'b1;
      rd(`ASCD_OFS_SYNC_CTRL, 8'h00, 8'hFF);
      rd(`ASCD_OFS_DCS_CTRL, 8'h01, 8'h01);
      rd(`ASCD_OFS_CLK_DIV, 8'h00, 8'h07);
      wr(12'h0FF, 8'(($urandom)));
      rd(12'h0FF, 8'h00, 8'hFF);
      k = $urandom % 256;
      wr(`ASCD_OFS_SYNC_CTRL, 8'(k));
      rd(`ASCD_OFS_SYNC_CTRL, 8'(k), 8'hFF);
      for (i = 0; i < 16; i++) begin
         r = (i < 8) ? i + 1 : $urandom % 8 + 1;
         d = (r == 1 || r == 2 || r == 4) ? 1'($urandom % 2) : 1'b1;
         act = d && r <= 5;
         h = act ? (r + 1) / 2 : 1;
         wr(`ASCD_OFS_CLK_DIV, 8'(r - 1));
         repeat (10) tk;
         wr(`ASCD_OFS_DCS_CTRL, {7'h00, d});
         repeat (170) tk;
         @(negedge ref_clk_in);
         chk({7'h00, dcs_active_out}, {7'h00, act});
         chk({7'h00, dcs_locked_out}, {7'h00, act});
         rd(`ASCD_OFS_STATUS, 8'((r - 1) << 4), 8'h70);
         wr(`ASCD_OFS_SYNC_CTRL, 8'h02);
         do_sync(1'b1);
         for (k = 0; k < 2 * r; k++) begin
            if (k > 0) begin
               tk;
               @(negedge ref_clk_in);
            end
            ec = (k % r) < h;
            es = (k % r) == 0;
            chk({7'h00, conv_clk_out}, {7'h00, ec});
            chk({7'h00, sample_strobe_out}, {7'h00, es});
         end
      end
      wr(`ASCD_OFS_CLK_DIV, 8'h07);
      repeat (10) tk;
      wr(`ASCD_OFS_SYNC_CTRL, 8'h06);
      do_sync(1'b1);
      do_sync(1'b0);
      rd(`ASCD_OFS_STATUS, 8'h78, 8'h7E);
      wr(`ASCD_OFS_SYNC_CTRL, 8'h02);
      do_sync(1'b1);
      do_sync(1'b1);
      wr(`ASCD_OFS_SYNC_CTRL, 8'h06);
      do_sync(1'b1);
      wr(`ASCD_OFS_SYNC_CTRL, 8'h00);
      do_sync(1'b0);
      rd(`ASCD_OFS_STATUS, 8'h72, 8'h7E);
      tally_and_finish;
   end
endmodule
